// ### hdl/daf_core.sv
// Data address generator and ALU flag register with a Wishbone slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Flag-affecting result into status: update flags only
// - Status bits 7 to 5 read zero
// - Negative flag copies result bit 7
// - Overflow flag marks wrong signed sign change
// - Zero flag set when result is zero
// - Nibble carry records carry out of bit 3
// - Carry records carry out of bit 7
// - Subtract adds complement; carries mean not-borrow
// - Rotate loads nibble carry from bit 4/3
// - Rotate loads carry from shifted-out bit
// - Access bit 1: bank value joins address byte
// - Access bit 0: byte is access-bank location
// - Full 12-bit opcode address ignores bank value
// - Dest bit 1 to file, 0 to accumulator
// - Three 12-bit pointer pairs, high nibble unused
// - Virtual operand accesses pair's pointed location
// - Indirect address ignores bank value, access bit
// - Offset mode only with extended set enabled
// - Extended, access 0, byte<=5Fh: third pair plus byte
// - Post/pre step by one, plus-accumulator keeps pointer
// - Pointer steps carry across bytes, flags untouched
module daf_core
  import daf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Data memory side
  output logic [11:0]      dmem_addr_o,
  output logic [7:0]       dmem_wdata_o,
  output logic             dmem_we_o
);
  // Register state
  logic [4:0]  flags_reg, flags_next;
  logic [3:0]  bank_reg, bank_next;
  logic [7:0]  acc_reg, acc_next;
  logic [11:0] ptr_reg [3];
  logic [11:0] ptr_next [3];
  logic        ext_reg, ext_next;
  logic [7:0]  operand_reg, operand_next;
  logic [7:0]  result_reg, result_next;
  logic [11:0] target_reg, target_next;
  logic [2:0]  tgt_bits_reg, tgt_bits_next;
  logic        we_reg, we_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  // Combinational helpers
  logic        req, wr_ack, exec;
  logic [31:0] wval, wnew;
  logic [3:0]  cmd_op;
  logic        cmd_a, cmd_d;
  logic [1:0]  cmd_mode;
  logic [7:0]  cmd_file;
  logic [11:0] cmd_full;
  logic [11:0] base_addr, eff_addr;
  logic [4:0]  vdec;
  logic [1:0]  vpair;
  logic [2:0]  vkind;
  logic [11:0] vptr;
  logic        status_hit;
  logic [7:0]  alu_result;
  logic [4:0]  alu_mask, alu_flags_new;
  logic [3:0]  psel;

  // Byte-lane merge so a partial write leaves the other lanes alone
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Pointer byte decode: {hit, high, pair}; shared by read and write paths
  function automatic logic [3:0] ptr_decode(input logic [7:0] adr);
    logic [3:0] r;
    r = 4'h0;
    for (int n = 0; n < 3; n++) begin
      if (adr == ADR_PTR_BASE + 8'(n) * ADR_PTR_STEP) begin
        r = {1'b1, 1'b0, 2'(n)};
      end
      if (adr == ADR_PTR_BASE + 8'(n) * ADR_PTR_STEP + ADR_HIGH_OFS) begin
        r = {1'b1, 1'b1, 2'(n)};
      end
    end
    return r;
  endfunction : ptr_decode

  // Virtual operand decode: {pair, kind}; five operands per pair
  function automatic logic [4:0] vdecode(input logic [11:0] a);
    logic [4:0]  r;
    logic [11:0] top;
    r = {2'h0, VK_NONE};
    for (int n = 0; n < 3; n++) begin
      top = VIRT_TOP - 12'(n) * VIRT_STRIDE;
      case (top - a)
        12'h000: r = {2'(n), VK_PLAIN};
        12'h001: r = {2'(n), VK_AFTER_ACCESS_INCREMENT_OPERAND};
        12'h002: r = {2'(n), VK_AFTER_ACCESS_DECREMENT_OPERAND};
        12'h003: r = {2'(n), VK_BEFORE_ACCESS_INCREMENT_OPERAND};
        12'h004: r = {2'(n), VK_POINTER_PLUS_ACCUMULATOR_OPERAND};
        default: r = r;
      endcase
    end
    return r;
  endfunction : vdecode

  // ALU with flag generation
  daf_flag_unit u_flags (
    .op_i     (cmd_op),
    .src_i    (operand_reg),
    .acc_i    (acc_reg),
    .carry_i  (flags_reg[FLG_C]),
    .result_o (alu_result),
    .mask_o   (alu_mask),
    .flags_o  (alu_flags_new)
  );

  // Command fields and address resolution
  always_comb begin
    req      = wb_cyc_i && wb_stb_i;
    wr_ack   = req && wb_we_i && ack_reg;
    exec     = wr_ack && (wb_adr_i == ADR_COMMAND);
    wval     = wmerge(32'h0, wb_dat_i, wb_sel_i);
    cmd_op   = wval[CMD_OP_LSB +: 4];
    cmd_a    = wval[CMD_ACCESS];
    cmd_d    = wval[CMD_DEST];
    cmd_mode = wval[CMD_MODE_LSB +: 2];
    cmd_file = wval[CMD_FILE_LSB +: 8];
    cmd_full = wval[CMD_FULL_LSB +: 12];
    psel     = ptr_decode(wb_adr_i);
    if (cmd_mode == MODE_FULL) begin
      base_addr = cmd_full;
    end else if (ext_reg && !cmd_a && cmd_file <= OFFSET_LIMIT) begin
      base_addr = ptr_reg[2] + {4'h0, cmd_file};
    end else if (cmd_a) begin
      base_addr = {bank_reg, cmd_file};
    end else if (cmd_file >= ACCESS_SPLIT) begin
      base_addr = {ACCESS_HIGH, cmd_file};
    end else begin
      base_addr = {ACCESS_LOW, cmd_file};
    end
    vdec  = vdecode(base_addr);
    vpair = vdec[4:3];
    vkind = vdec[2:0];
    vptr  = ptr_reg[vpair];
    // Indirect target is the whole pointer; bank value and access bit drop out
    case (vkind)
      VK_PLAIN, VK_AFTER_ACCESS_INCREMENT_OPERAND, VK_AFTER_ACCESS_DECREMENT_OPERAND: eff_addr = vptr;
      VK_BEFORE_ACCESS_INCREMENT_OPERAND: eff_addr = vptr + 12'h001;
      VK_POINTER_PLUS_ACCUMULATOR_OPERAND:  eff_addr = vptr + {{4{acc_reg[7]}}, acc_reg};
      default:   eff_addr = base_addr;
    endcase
    status_hit = cmd_d && (eff_addr == STATUS_ADDR);
  end

  // Next state of the register file and execution results
  always_comb begin
    flags_next    = flags_reg;
    bank_next     = bank_reg;
    acc_next      = acc_reg;
    ext_next      = ext_reg;
    operand_next  = operand_reg;
    result_next   = result_reg;
    target_next   = target_reg;
    tgt_bits_next = tgt_bits_reg;
    we_next       = 1'b0;
    for (int n = 0; n < 3; n++) begin
      ptr_next[n] = ptr_reg[n];
    end
    // Merge onto the word as read, so unselected lanes keep their contents
    wnew = wmerge(rdat_next, wb_dat_i, wb_sel_i);
    if (wr_ack) begin
      case (wb_adr_i)
        ADR_FLAGS:   flags_next = wnew[FLAGS_W-1:0];
        ADR_BANK:    bank_next = wnew[3:0];
        ADR_ACC:     acc_next = wnew[7:0];
        ADR_CONFIG:  ext_next = wnew[0];
        ADR_OPERAND: operand_next = wnew[7:0];
        default:     ext_next = ext_reg;
      endcase
      // Only the low nibble of a high byte is kept
      if (psel[3] && wb_sel_i[0]) begin
        if (psel[2]) begin
          ptr_next[psel[1:0]][11:8] = wb_dat_i[3:0];
        end else begin
          ptr_next[psel[1:0]][7:0] = wb_dat_i[7:0];
        end
      end
    end
    if (exec) begin
      result_next   = alu_result;
      target_next   = eff_addr;
      tgt_bits_next = {status_hit, vkind != VK_NONE, !cmd_d};
      // Steps run on the full 12 bits so low-byte wrap reaches the high byte
      case (vkind)
        VK_AFTER_ACCESS_INCREMENT_OPERAND, VK_BEFORE_ACCESS_INCREMENT_OPERAND: ptr_next[vpair] = vptr + 12'h001;
        VK_AFTER_ACCESS_DECREMENT_OPERAND:            ptr_next[vpair] = vptr - 12'h001;
        default:               ptr_next[vpair] = ptr_next[vpair];
      endcase
      if (status_hit && alu_mask == 5'h00) begin
        flags_next = alu_result[FLAGS_W-1:0];
      end else begin
        flags_next = (flags_reg & ~alu_mask) | (alu_flags_new & alu_mask);
      end
      if (!cmd_d) begin
        acc_next = alu_result;
      end else if (!status_hit) begin
        we_next = 1'b1;
      end
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_next  = req && !ack_reg;
    rdat_next = 32'h0;
    case (wb_adr_i)
      ADR_FLAGS:   rdat_next = {27'h0, flags_reg};
      ADR_BANK:    rdat_next = {28'h0, bank_reg};
      ADR_ACC:     rdat_next = {24'h0, acc_reg};
      ADR_CONFIG:  rdat_next = {31'h0, ext_reg};
      ADR_OPERAND: rdat_next = {24'h0, operand_reg};
      ADR_RESULT:  rdat_next = {24'h0, result_reg};
      ADR_TARGET:  rdat_next = {17'h0, tgt_bits_reg, target_reg};
      default:     rdat_next = 32'h0;
    endcase
    if (psel[3]) begin
      rdat_next = psel[2] ? {28'h0, ptr_reg[psel[1:0]][11:8]}
                          : {24'h0, ptr_reg[psel[1:0]][7:0]};
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg    <= FLAGS_RST;
      bank_reg     <= 4'h0;
      acc_reg      <= BYTE_RST;
      ext_reg      <= 1'b0;
      operand_reg  <= BYTE_RST;
      result_reg   <= BYTE_RST;
      target_reg   <= PTR_RST;
      tgt_bits_reg <= 3'h0;
      we_reg       <= 1'b0;
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0;
      for (int n = 0; n < 3; n++) begin
        ptr_reg[n] <= PTR_RST;
      end
    end else begin
      flags_reg    <= flags_next;
      bank_reg     <= bank_next;
      acc_reg      <= acc_next;
      ext_reg      <= ext_next;
      operand_reg  <= operand_next;
      result_reg   <= result_next;
      target_reg   <= target_next;
      tgt_bits_reg <= tgt_bits_next;
      we_reg       <= we_next;
      ack_reg      <= ack_next;
      rdat_reg     <= rdat_next;
      for (int n = 0; n < 3; n++) begin
        ptr_reg[n] <= ptr_next[n];
      end
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o     = rdat_reg;
  assign wb_ack_o     = ack_reg;
  assign dmem_addr_o  = target_reg;
  assign dmem_wdata_o = result_reg;
  assign dmem_we_o    = we_reg;

  // Checks
  chk_flags_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_reg && wb_adr_i == ADR_FLAGS |-> rdat_reg[7:5] == 3'b000)
    else $error("status upper bits not zero");
  chk_dest_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && !cmd_d |=> acc_reg == result_reg && !dmem_we_o)
    else $error("result not routed to accumulator");
  chk_status_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && status_hit |=> !dmem_we_o && tgt_bits_reg[2])
    else $error("status destination result was written out");
  chk_flags_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && alu_mask == 5'h00 && !status_hit |=> flags_reg == $past(flags_reg))
    else $error("unaffected flags changed");
  chk_neg_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && alu_mask[FLG_N] && !status_hit |=>
    flags_reg[FLG_N] == result_reg[7] && flags_reg[FLG_Z] == (result_reg == 8'h00))
    else $error("negative or zero flag wrong");
  chk_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cmd_op == OP_SUB && !status_hit |=>
    flags_reg[FLG_C] == ($past(operand_reg) >= $past(acc_reg)))
    else $error("subtract carry is not inverted borrow");
  chk_bank_join: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && cmd_mode == MODE_BYTE && cmd_a && vkind == VK_NONE |=>
    target_reg == {$past(bank_reg), $past(cmd_file)})
    else $error("bank join address wrong");
  chk_offset_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && ext_reg && cmd_mode == MODE_BYTE && !cmd_a && cmd_file <= OFFSET_LIMIT
    && vkind == VK_NONE |=> target_reg == $past(ptr_reg[2]) + {4'h0, $past(cmd_file)})
    else $error("offset address wrong");
  chk_after_access_increment_operand_step: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && vkind == VK_AFTER_ACCESS_INCREMENT_OPERAND && vpair == 2'h0 |=>
    ptr_reg[0] == $past(ptr_reg[0]) + 12'h001 && target_reg == $past(ptr_reg[0]))
    else $error("post increment wrong");
  chk_pointer_plus_accumulator_operand_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && vkind == VK_POINTER_PLUS_ACCUMULATOR_OPERAND && vpair == 2'h0 |=> ptr_reg[0] == $past(ptr_reg[0]))
    else $error("plus accumulator changed pointer");
  chk_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_reg |=> !ack_reg)
    else $error("ack held two cycles");
endmodule : daf_core
`default_nettype wire

// ### hdl/daf_flag_unit.sv
// ALU result and flag computation
`timescale 1ns/10ps
`default_nettype none
module daf_flag_unit
  import daf_pkg::*;
(
  // Operation and operands
  input  wire logic [3:0] op_i,
  input  wire logic [7:0] src_i,
  input  wire logic [7:0] acc_i,
  input  wire logic       carry_i,
  // Result and flags
  output logic [7:0]      result_o,
  output logic [4:0]      mask_o,
  output logic [4:0]      flags_o
);
  logic [7:0] addend;
  logic [8:0] sum;
  logic [4:0] nib;
  logic       sub;

  // Subtract adds the complement plus one, so carries read as not-borrow
  always_comb begin
    sub    = (op_i == OP_SUB);
    addend = sub ? ~acc_i : acc_i;
    sum    = {1'b0, src_i} + {1'b0, addend} + {8'h00, sub};
    nib    = {1'b0, src_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
    result_o = src_i;
    mask_o   = 5'h00;
    flags_o  = 5'h00;
    case (op_i)
      OP_ADD, OP_SUB: begin
        result_o        = sum[7:0];
        mask_o          = 5'h1f;
        flags_o[FLG_C]  = sum[8];
        flags_o[FLG_DC] = nib[4];
        flags_o[FLG_OV] = (src_i[7] == addend[7]) && (sum[7] != src_i[7]);
      end
      OP_AND: result_o = src_i & acc_i;
      OP_IOR: result_o = src_i | acc_i;
      OP_XOR: result_o = src_i ^ acc_i;
      OP_MOV: result_o = src_i;
      OP_CLR: result_o = 8'h00;
      OP_RLF: begin
        result_o        = {src_i[6:0], carry_i};
        flags_o[FLG_C]  = src_i[7];
        flags_o[FLG_DC] = src_i[3];
      end
      OP_RRF: begin
        result_o        = {carry_i, src_i[7:1]};
        flags_o[FLG_C]  = src_i[0];
        flags_o[FLG_DC] = src_i[4];
      end
      OP_MOVW: result_o = acc_i;
      default: result_o = src_i;
    endcase
    // Which flags each operation touches; the rest are kept by the caller
    case (op_i)
      OP_AND, OP_IOR, OP_XOR, OP_MOV: mask_o = 5'h14;
      OP_CLR:                         mask_o = 5'h04;
      OP_RLF, OP_RRF:                 mask_o = 5'h17;
      default:                        mask_o = mask_o;
    endcase
    flags_o[FLG_Z] = (result_o == 8'h00);
    flags_o[FLG_N] = result_o[7];
  end
endmodule : daf_flag_unit
`default_nettype wire

// ### hdl/daf_pkg.sv
// Shared constants and types for the data address and ALU flag block
package daf_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ADR_FLAGS    = 8'h00;
  localparam logic [7:0] ADR_BANK     = 8'h04;
  localparam logic [7:0] ADR_ACC      = 8'h08;
  localparam logic [7:0] ADR_PTR_BASE = 8'h0c;
  localparam logic [7:0] ADR_PTR_STEP = 8'h08;
  localparam logic [7:0] ADR_HIGH_OFS = 8'h04;
  localparam logic [7:0] ADR_CONFIG   = 8'h24;
  localparam logic [7:0] ADR_OPERAND  = 8'h28;
  localparam logic [7:0] ADR_COMMAND  = 8'h2c;
  localparam logic [7:0] ADR_RESULT   = 8'h30;
  localparam logic [7:0] ADR_TARGET   = 8'h34;
  // Flag bit positions inside alu_flags
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  localparam int FLAGS_W = 5;
  // Command word fields and target readback bits
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ACCESS   = 4;
  localparam int CMD_DEST     = 5;
  localparam int CMD_MODE_LSB = 6;
  localparam int CMD_FILE_LSB = 8;
  localparam int CMD_FULL_LSB = 16;
  localparam int TGT_TO_ACC   = 12;
  localparam int TGT_VIRTUAL  = 13;
  localparam int TGT_STATUS   = 14;
  // Data space constants
  localparam logic [11:0] STATUS_ADDR  = 12'hfd8;
  localparam logic [11:0] VIRT_TOP     = 12'hfef;
  localparam logic [11:0] VIRT_STRIDE  = 12'h008;
  localparam logic [7:0]  OFFSET_LIMIT = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
  localparam logic [3:0]  ACCESS_LOW   = 4'h0;
  // Values after reset
  localparam logic [4:0]  FLAGS_RST = 5'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [11:0] PTR_RST   = 12'h000;
  // ALU operations
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
    OP_XOR = 4'h4, OP_MOV = 4'h5, OP_CLR = 4'h6, OP_RLF = 4'h7,
    OP_RRF = 4'h8, OP_MOVW = 4'h9, OP_NOP = 4'hf
  } daf_op_t;
  // Address modes
  typedef enum logic [1:0] {MODE_BYTE = 2'h0, MODE_FULL = 2'h1} daf_mode_t;
  // Virtual operand kinds
  typedef enum logic [2:0] {
    VK_NONE = 3'h0, VK_PLAIN = 3'h1, VK_AFTER_ACCESS_INCREMENT_OPERAND = 3'h2,
    VK_AFTER_ACCESS_DECREMENT_OPERAND = 3'h3, VK_BEFORE_ACCESS_INCREMENT_OPERAND = 3'h4, VK_POINTER_PLUS_ACCUMULATOR_OPERAND = 3'h5
  } daf_vkind_t;
endpackage : daf_pkg

// ### sim/daf_core_tb.sv
// Self-checking bench for the data address and flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module daf_core_tb;
  import daf_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  lanes = 4'hf;
  logic [31:0] exp_r;
  logic [19:0] exp_d;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [11:0] dmem_addr_o;
  logic [7:0]  dmem_wdata_o;
  logic        dmem_we_o;
  logic [15:0] writes;
  logic [15:0] n_wr = 16'h0000;
  logic [4:0]  flg = 5'h00;
  logic [7:0]  acc = 8'h00;
  logic [31:0] rq[$];
  logic [19:0] dq[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  daf_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dmem_addr_o(dmem_addr_o), .dmem_wdata_o(dmem_wdata_o), .dmem_we_o(dmem_we_o));
  daf_dmem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(dmem_addr_o),
    .wdata_i(dmem_wdata_o), .we_i(dmem_we_o), .writes_o(writes));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("Comparisons %0d, failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Monitor: each result that appears is matched against the oldest note
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
    // Notes are popped once, before the compare, so a failure cannot skip one
    if (wb_ack_o === 1'b1 && !we) begin
      exp_r = (rq.size() > 0) ? rq.pop_front() : 32'hdead_beef;
      `CHK("read data", exp_r, wb_dat_o)
    end
    if (dmem_we_o === 1'b1) begin
      exp_d = (dq.size() > 0) ? dq.pop_front() : 20'hfffff;
      `CHK("memory write", exp_d, {dmem_addr_o, dmem_wdata_o})
    end
  end

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    sel <= lanes;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    cyc <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic setf(input logic [31:0] v);
    flg = v[4:0];
    wb(1'b1, ADR_FLAGS, v);
  endtask : setf

  task automatic setw(input logic [7:0] v);
    acc = v;
    wb(1'b1, ADR_ACC, {24'h000000, v});
  endtask : setw

  // Reference ALU: returns the result, updates only the flags the op affects
  function automatic logic [7:0] alu(input logic [3:0] op, input logic [7:0] s,
                                     input logic [7:0] b, inout logic [4:0] f);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] k;
    logic [7:0] y;
    k = (op == 4'h1) ? ~b : b;
    t = {1'b0, s} + {1'b0, k} + {8'h00, op == 4'h1};
    h = {1'b0, s[3:0]} + {1'b0, k[3:0]} + {4'h0, op == 4'h1};
    case (op)
      4'h0, 4'h1: begin
        y = t[7:0];
        f = {y[7], (s[7] == k[7]) && (y[7] != s[7]), y == 8'h00, h[4], t[8]};
      end
      4'h2: y = s & b;
      4'h3: y = s | b;
      4'h4: y = s ^ b;
      4'h6: y = 8'h00;
      4'h7: begin
        y = {s[6:0], f[0]};
        f = {y[7], f[3], y == 8'h00, s[3], s[7]};
      end
      4'h8: begin
        y = {f[0], s[7:1]};
        f = {y[7], f[3], y == 8'h00, s[4], s[0]};
      end
      default: y = (op == 4'h9) ? b : s;
    endcase
    if (op inside {[4'h2:4'h5]}) f = {y[7], f[3], y == 8'h00, f[1:0]};
    if (op == 4'h6) f[2] = 1'b1;
    return y;
  endfunction : alu

  // Run one command; ctl is {mode, d, a}; ea is the address it must resolve to
  task automatic exe(input logic [3:0] op, input logic [7:0] src, input logic [3:0] ctl,
                     input logic [7:0] byt, input logic [11:0] full, input logic [11:0] ea);
    logic [7:0] y;
    y = alu(op, src, acc, flg);
    if (!ctl[1]) acc = y;
    else if (ea == STATUS_ADDR && op >= 4'h9) flg = y[4:0];
    else if (ea != STATUS_ADDR) begin
      dq.push_back({ea, y});
      n_wr++;
    end
    wb(1'b1, ADR_OPERAND, {24'h000000, src});
    wb(1'b1, ADR_COMMAND, {4'h0, full, byt, ctl, op});
    rd(ADR_FLAGS, {27'h0000000, flg});
    rd(ADR_ACC, {24'h000000, acc});
    rd(ADR_RESULT, {24'h000000, y});
  endtask : exe

  task automatic ptr(input int n, input logic [7:0] lo, input logic [7:0] hi, input logic w);
    if (w) wb(1'b1, 8'(ADR_PTR_BASE + n * ADR_PTR_STEP), {24'h000000, lo});
    if (w) wb(1'b1, 8'(ADR_PTR_BASE + n * ADR_PTR_STEP + ADR_HIGH_OFS), {24'h0000f0, hi});
    rd(8'(ADR_PTR_BASE + n * ADR_PTR_STEP), {24'h000000, lo});
    rd(8'(ADR_PTR_BASE + n * ADR_PTR_STEP + ADR_HIGH_OFS), {28'h0000000, hi[3:0]});
  endtask : ptr

  initial begin
    logic [3:0] op;
    void'($urandom(9635));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Every register and the unmapped words read zero after reset
    for (int i = 0; i < 16; i++) rd(8'(4 * i), 32'h0000_0000);
    wb(1'b1, 8'h3c, 32'h0000_005a);
    rd(8'h3c, 32'h0000_0000);
    // Byte lanes: unselected lanes stay, pointer bytes need lane 0
    lanes = 4'he;
    wb(1'b1, ADR_ACC, 32'h0000_0077);
    wb(1'b1, ADR_PTR_BASE, 32'h0000_0012);
    lanes = 4'h1;
    wb(1'b1, ADR_BANK, 32'hffff_ff3c);
    lanes = 4'hf;
    rd(ADR_ACC, 32'h0000_0000);
    rd(ADR_PTR_BASE, 32'h0000_0000);
    rd(ADR_BANK, 32'h0000_000c);
    setf(32'hffff_ffff);
    rd(ADR_FLAGS, 32'h0000_001f);
    // Every op code with random operands and prior flags
    for (int i = 0; i < 44; i++) begin
      op = (i % 11 == 10) ? 4'hf : 4'(i % 11);
      setf($urandom);
      setw(8'($urandom));
      exe(op, 8'($urandom), 4'h4, 8'h00, 12'h000, 12'h000);
    end
    // Signed overflow and borrow edges
    setw(8'h01);
    exe(4'h0, 8'h7f, 4'h4, 8'h00, 12'h000, 12'h000);
    setw(8'h01);
    exe(4'h1, 8'h00, 4'h4, 8'h00, 12'h000, 12'h000);
    // Status register as the destination
    setf(32'h0000_001b);
    setw(8'h35);
    exe(4'h6, 8'h44, 4'h6, 8'h00, STATUS_ADDR, STATUS_ADDR);
    exe(4'h9, 8'h44, 4'h6, 8'h00, STATUS_ADDR, STATUS_ADDR);
    exe(4'h0, 8'h44, 4'h6, 8'h00, STATUS_ADDR, STATUS_ADDR);
    // Direct addressing, plain and extended
    wb(1'b1, ADR_BANK, 32'h0000_0005);
    ptr(2, 8'h23, 8'hf1, 1'b1);
    for (int x = 0; x < 2; x++) begin
      wb(1'b1, ADR_CONFIG, 32'(x));
      exe(4'h5, 8'($urandom), 4'h3, 8'h34, 12'hfff, 12'h534);
      exe(4'h5, 8'($urandom), 4'h2, 8'h90, 12'hfff, 12'hf90);
      exe(4'h5, 8'($urandom), 4'h2, 8'h5f, 12'hfff, (x == 1) ? 12'h182 : 12'h05f);
      exe(4'h5, 8'($urandom), 4'h2, 8'h60, 12'hfff, 12'h060);
      exe(4'h5, 8'($urandom), 4'h7, 8'h34, 12'habc, 12'habc);
    end
    // Virtual operands on pairs 0 and 1, pair 0 stepping across the byte boundary
    ptr(0, 8'hff, 8'h00, 1'b1);
    setw(8'hfe);
    exe(4'h9, 8'h00, 4'h7, 8'h00, 12'hfef, 12'h0ff);
    ptr(0, 8'hff, 8'h00, 1'b0);
    exe(4'h9, 8'h00, 4'h7, 8'h00, 12'hfee, 12'h0ff);
    ptr(0, 8'h00, 8'h01, 1'b0);
    exe(4'h9, 8'h00, 4'h7, 8'h00, 12'hfed, 12'h100);
    ptr(0, 8'hff, 8'h00, 1'b0);
    exe(4'h9, 8'h00, 4'h7, 8'h00, 12'hfec, 12'h100);
    exe(4'h9, 8'h00, 4'h7, 8'h00, 12'hfeb, 12'h0fe);
    ptr(0, 8'h00, 8'h01, 1'b0);
    exe(4'h9, 8'h00, 4'h2, 8'he7, 12'h000, 12'h000);
    repeat (4) @(posedge clk_i);
    `CHK("write count", n_wr, writes)
    `CHK("notes left", 32'(rq.size() + dq.size()), 32'h0000_0000)
    complete_run();
  end
endmodule : daf_core_tb
`default_nettype wire

// ### sim/daf_dmem_model.sv
// Data memory stand-in that keeps and counts the writes it receives
`timescale 1ns/10ps
`default_nettype none
module daf_dmem_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Write port from the block
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  // Write count for the bench
  output logic [15:0]      writes_o
);
  logic [7:0] mem_reg [4096];
  // No read path: the block only ever writes results out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      writes_o <= 16'h0000;
    end else if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
      writes_o        <= writes_o + 16'h0001;
    end
  end
endmodule : daf_dmem_model
`default_nettype wire
